// ===== dscu_pkg.sv
// Summary of operation
// - interface error flags ignore, read, write and checksum are sticky, cleared by writing one
// - clock-count error flag at bit 3 is read-only, a write of one leaves it
// - clock-count check counts only for transactions framed by chip select
// - converter fault register reports regulator, reference, saturation, unsettled faults read-only
// - missing clock fault goes to master status and converter fault bit 0, not into converter summary
// - digital fault register reports regmap, ram and fuse checksum faults; other bits zero
// - eight-bit read-only counter advances once every 64 master clock cycles
// - coefficient memory reached through data port only while access enable is set
// - data port write updates coefficient memory only when write enable is set
// - six-bit index selects one of 56 coefficients; host keeps index within 0..55
// - data port carries 23-bit coefficient value in bits 22 down to 0
// - keep-user flag set means a sync does not reload default coefficients
// - key register bit 0 reads one after correct key written, else zero
package dscu_pkg;
	localparam logic [6:0]  ADDR_SPI_ERR    = 7'h2e;
	localparam logic [6:0]  ADDR_CONV_FAULT = 7'h2f;
	localparam logic [6:0]  ADDR_DIG_FAULT  = 7'h30;
	localparam logic [6:0]  ADDR_TICK_CNT   = 7'h31;
	localparam logic [6:0]  ADDR_COEF_CTRL  = 7'h32;
	localparam logic [6:0]  ADDR_COEF_DATA  = 7'h33;
	localparam logic [6:0]  ADDR_UNLOCK     = 7'h34;
	localparam logic [7:0]  SPI_W1C_MASK    = 8'h17;
	localparam int          SPI_CLKCNT_BIT  = 3;
	localparam logic [7:0]  CONV_MASK       = 8'h3e;
	localparam int          CONV_CLK_BIT    = 0;
	localparam logic [7:0]  DIG_MASK        = 8'h1c;
	localparam int          CTRL_ACCESS_BIT = 7;
	localparam int          CTRL_WRITE_BIT  = 6;
	localparam int          KEEP_USER_BIT   = 23;
	localparam int          TICK_DIV        = 64;
	localparam int          COEF_COUNT      = 56;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [23:0] RESET_WORD      = 24'h000000;
	localparam logic [7:0]  UNLOCK_KEY_DEF  = 8'ha5;
endpackage : dscu_pkg

// ===== dscu_tick.sv
`timescale 1ns/100ps
module dscu_tick #(
	parameter int DIV = 64
) (
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	// control and count
	input  wire logic       i_enable,
	output logic      [7:0] o_count
);
	localparam int PW = $clog2(DIV);
	initial
	begin
		if (DIV < 2 || (1 << PW) != DIV)
			$error("dscu_tick: DIV must be a power of two >= 2");
	end
	logic [PW-1:0] pre_reg;
	logic [PW-1:0] pre_next;
	logic [7:0]    cnt_reg;
	logic [7:0]    cnt_next;
	always_comb
	begin
		pre_next = pre_reg;
		cnt_next = cnt_reg;
		if (i_enable)
		begin
			pre_next = pre_reg + 1'b1;
			if (pre_reg == PW'(DIV - 1))
				cnt_next = cnt_reg + 8'h01;
		end
	end
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pre_reg <= '0;
			cnt_reg <= 8'h00;
		end
		else
		begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
		end
	end
	assign o_count = cnt_reg;
endmodule : dscu_tick

// ===== dscu_regs.sv
`timescale 1ns/100ps
module dscu_regs #(
	parameter logic [7:0] UNLOCK_KEY = dscu_pkg::UNLOCK_KEY_DEF, // arbitrary value
	parameter int         COEFS      = dscu_pkg::COEF_COUNT
) (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset,
	// register port from serial interface
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic  [6:0] i_reg_addr,
	input  wire logic [23:0] i_reg_wdata,
	output logic      [23:0] o_reg_rdata,
	// interface error events, one-cycle pulses
	input  wire logic        i_ev_ignore,
	input  wire logic        i_ev_rd_err,
	input  wire logic        i_ev_wr_err,
	input  wire logic        i_ev_crc_err,
	input  wire logic        i_ev_clk_cnt,
	input  wire logic        i_cs_framed,
	// fault levels from analog and digital monitors
	input  wire logic  [5:0] i_conv_fault,
	input  wire logic  [4:2] i_dig_fault,
	input  wire logic        i_tick_enable,
	// filter side
	input  wire logic        i_sync,
	output logic             o_conv_summary,
	output logic             o_missing_clock_fault,
	output logic             o_reload_rom,
	output logic             o_coef_unlocked
);
	initial
	begin
		if (COEFS < 1 || COEFS > 64)
			$error("dscu_regs: COEFS must be 1..64");
	end

	// monitor inputs come from other domains
	logic [5:0] conv_s1_reg;
	logic [5:0] conv_s2_reg;
	logic [4:2] dig_s1_reg;
	logic [4:2] dig_s2_reg;
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			conv_s1_reg <= '0;
			conv_s2_reg <= '0;
			dig_s1_reg  <= '0;
			dig_s2_reg  <= '0;
		end
		else
		begin
			conv_s1_reg <= i_conv_fault;
			conv_s2_reg <= conv_s1_reg;
			dig_s1_reg  <= i_dig_fault;
			dig_s2_reg  <= dig_s1_reg;
		end
	end

	logic [7:0] tick_count;
	dscu_tick #(
		.DIV (dscu_pkg::TICK_DIV)
	) u_tick (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_enable  (i_tick_enable),
		.o_count   (tick_count)
	);

	logic [23:0] coef_mem [COEFS];
	logic  [7:0] spi_err_reg;
	logic  [7:0] spi_err_next;
	logic  [7:0] ctrl_reg;
	logic  [7:0] ctrl_next;
	logic        keep_user_reg;
	logic        keep_user_next;
	logic [22:0] coef_value_reg;
	logic [22:0] coef_value_next;
	logic        unlocked_reg;
	logic        unlocked_next;
	logic [23:0] rdata_reg;
	logic [23:0] rdata_next;
	logic        summary_reg;
	logic        mclk_fault_reg;
	logic        reload_reg;
	logic        reload_next;
	logic        mem_we;
	logic        coef_access_enable;
	logic        coef_write_enable;
	logic  [5:0] coef_index;
	logic        idx_ok;
	logic  [7:0] conv_view;
	logic  [7:0] dig_view;

	assign coef_access_enable = ctrl_reg[dscu_pkg::CTRL_ACCESS_BIT];
	assign coef_write_enable  = ctrl_reg[dscu_pkg::CTRL_WRITE_BIT];
	assign coef_index         = ctrl_reg[5:0];
	assign idx_ok             = 32'(coef_index) < COEFS;
	// missing clock bit stays visible here; only the summary leaves it out
	assign conv_view          = {2'b00, conv_s2_reg};
	assign dig_view           = {3'b000, dig_s2_reg, 2'b00} & dscu_pkg::DIG_MASK;

	always_comb
	begin
		spi_err_next    = spi_err_reg;
		ctrl_next       = ctrl_reg;
		keep_user_next  = keep_user_reg;
		coef_value_next = coef_value_reg;
		unlocked_next   = unlocked_reg;
		rdata_next      = rdata_reg;
		reload_next     = 1'b0;
		mem_we          = 1'b0;
		// clear first, then set, so an event in the clear cycle survives
		if (i_reg_wr && i_reg_addr == dscu_pkg::ADDR_SPI_ERR)
			spi_err_next = spi_err_reg & ~(i_reg_wdata[7:0] & dscu_pkg::SPI_W1C_MASK);
		spi_err_next[4] = spi_err_next[4] | i_ev_ignore;
		spi_err_next[2] = spi_err_next[2] | i_ev_rd_err;
		spi_err_next[1] = spi_err_next[1] | i_ev_wr_err;
		spi_err_next[0] = spi_err_next[0] | i_ev_crc_err;
		// clock-count flag has no software clear
		spi_err_next[dscu_pkg::SPI_CLKCNT_BIT] = spi_err_reg[dscu_pkg::SPI_CLKCNT_BIT]
			| (i_ev_clk_cnt & i_cs_framed);
		if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				dscu_pkg::ADDR_COEF_CTRL: ctrl_next = i_reg_wdata[7:0];
				dscu_pkg::ADDR_UNLOCK:    unlocked_next = (i_reg_wdata[7:0] == UNLOCK_KEY);
				dscu_pkg::ADDR_COEF_DATA:
				begin
					if (coef_access_enable)
					begin
						keep_user_next  = i_reg_wdata[dscu_pkg::KEEP_USER_BIT];
						coef_value_next = i_reg_wdata[22:0];
						mem_we          = coef_write_enable && idx_ok;
					end
				end
				default: ;
			endcase
		end
		if (i_sync && !keep_user_reg)
			reload_next = 1'b1;
		if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				dscu_pkg::ADDR_SPI_ERR:    rdata_next = {16'h0000, spi_err_reg};
				dscu_pkg::ADDR_CONV_FAULT: rdata_next = {16'h0000, conv_view};
				dscu_pkg::ADDR_DIG_FAULT:  rdata_next = {16'h0000, dig_view};
				dscu_pkg::ADDR_TICK_CNT:   rdata_next = {16'h0000, tick_count};
				dscu_pkg::ADDR_COEF_CTRL:  rdata_next = {16'h0000, ctrl_reg};
				dscu_pkg::ADDR_COEF_DATA:
				begin
					// memory is only visible while access is enabled
					if (coef_access_enable && idx_ok)
						rdata_next = coef_mem[coef_index[5:0]];
					else
						rdata_next = {keep_user_reg, coef_value_reg};
				end
				dscu_pkg::ADDR_UNLOCK:     rdata_next = {23'h000000, unlocked_reg};
				default:                   rdata_next = 24'h000000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			spi_err_reg    <= dscu_pkg::RESET_BYTE;
			ctrl_reg       <= dscu_pkg::RESET_BYTE;
			keep_user_reg  <= 1'b0;
			coef_value_reg <= 23'h000000;
			unlocked_reg   <= 1'b0;
			rdata_reg      <= dscu_pkg::RESET_WORD;
			summary_reg    <= 1'b0;
			mclk_fault_reg <= 1'b0;
			reload_reg     <= 1'b0;
		end
		else
		begin
			spi_err_reg    <= spi_err_next;
			ctrl_reg       <= ctrl_next;
			keep_user_reg  <= keep_user_next;
			coef_value_reg <= coef_value_next;
			unlocked_reg   <= unlocked_next;
			rdata_reg      <= rdata_next;
			summary_reg    <= |(conv_view & dscu_pkg::CONV_MASK);
			mclk_fault_reg <= conv_s2_reg[dscu_pkg::CONV_CLK_BIT];
			reload_reg     <= reload_next;
		end
	end

	// storage has no reset, as a ram would not
	always_ff @(posedge i_sys_clk)
	begin
		if (mem_we)
			coef_mem[coef_index[5:0]] <= {i_reg_wdata[dscu_pkg::KEEP_USER_BIT], i_reg_wdata[22:0]};
	end

	assign o_reg_rdata           = rdata_reg;
	assign o_conv_summary        = summary_reg;
	assign o_missing_clock_fault = mclk_fault_reg;
	assign o_reload_rom          = reload_reg;
	assign o_coef_unlocked       = unlocked_reg;
endmodule : dscu_regs

// ===== dscu_regs_monitor.sv
`timescale 1ns/100ps
module dscu_regs_monitor #(
	parameter logic [7:0] UNLOCK_KEY = 8'ha5
) (
	// clock and reset
	input wire logic        i_sys_clk,
	input wire logic        i_reset,
	// register port
	input wire logic        i_reg_wr,
	input wire logic        i_reg_rd,
	input wire logic  [6:0] i_reg_addr,
	input wire logic [23:0] i_reg_wdata,
	input wire logic [23:0] o_reg_rdata,
	// faults and filter side
	input wire logic  [5:0] i_conv_fault,
	input wire logic        i_sync,
	input wire logic        o_conv_summary,
	input wire logic        o_missing_clock_fault,
	input wire logic        o_reload_rom,
	input wire logic        o_coef_unlocked
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	sequence rd_at(a);
		$past(i_reg_rd) && $past(i_reg_addr) == a;
	endsequence
	sequence key_wr;
		$past(i_reg_wr) && $past(i_reg_addr) == dscu_pkg::ADDR_UNLOCK;
	endsequence
	spi_reserved_a: assert property (rd_at(dscu_pkg::ADDR_SPI_ERR) |-> o_reg_rdata[23:5] == 19'h0)
		else $error("spi error reserved bits set");
	dig_reserved_a: assert property (rd_at(dscu_pkg::ADDR_DIG_FAULT) |-> (o_reg_rdata & 24'hffffe3) == 24'h0)
		else $error("digital fault reserved bits set");
	key_reserved_a: assert property (rd_at(dscu_pkg::ADDR_UNLOCK) |-> o_reg_rdata[23:1] == 23'h0)
		else $error("key reserved bits set");
	unmapped_zero_a: assert property ($past(i_reg_rd) && $past(i_reg_addr) > 7'h34 |-> o_reg_rdata == 24'h0)
		else $error("unmapped read not zero");
	bad_key_a: assert property (key_wr and $past(i_reg_wdata[7:0]) != UNLOCK_KEY |-> ##[0:1] !o_coef_unlocked)
		else $error("wrong key unlocked");
	good_key_a: assert property (key_wr and $past(i_reg_wdata[7:0]) == UNLOCK_KEY |-> ##[0:1] o_coef_unlocked)
		else $error("right key not unlocked");
	clock_only_a: assert property ((i_conv_fault == 6'h01) [*5] |-> !o_conv_summary && o_missing_clock_fault)
		else $error("missing clock fault routed wrong");
	conv_sum_a: assert property ((i_conv_fault[5:1] != 5'h0) [*5] |-> o_conv_summary)
		else $error("converter summary missing");
	reload_cause_a: assert property (o_reload_rom |-> $past(i_sync))
		else $error("reload without sync");
	cover property (o_reload_rom);
	cover property (o_coef_unlocked);
	cover property (rd_at(dscu_pkg::ADDR_COEF_DATA));
endmodule : dscu_regs_monitor
bind dscu_regs dscu_regs_monitor #(.UNLOCK_KEY(UNLOCK_KEY)) i_mon (.i_sys_clk, .i_reset, .i_reg_wr, .i_reg_rd,
	.i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_conv_fault, .i_sync, .o_conv_summary, .o_missing_clock_fault,
	.o_reload_rom, .o_coef_unlocked);

// ===== dscu_host_model.sv
`timescale 1ns/100ps
module dscu_host_model #(
	parameter logic [7:0] KEY = 8'ha5 // arbitrary value
) (
	// clock and read data
	input  wire logic        i_sys_clk,
	input  wire logic [23:0] i_reg_rdata,
	// register strobes and sync
	output logic             o_reg_wr = 1'h0,
	output logic             o_reg_rd = 1'h0,
	output logic       [6:0] o_reg_addr = 7'h00,
	output logic      [23:0] o_reg_wdata = 24'h000000,
	output logic             o_sync = 1'h0
);
	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		@(posedge i_sys_clk);
		o_reg_wr <= 1'h1;
		o_reg_addr <= a;
		o_reg_wdata <= d;
		@(posedge i_sys_clk);
		o_reg_wr <= 1'h0;
		o_reg_addr <= ~a; // released bus shows no stale value
		o_reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [23:0] d);
		@(posedge i_sys_clk);
		o_reg_rd <= 1'h1;
		o_reg_addr <= a;
		@(posedge i_sys_clk);
		o_reg_rd <= 1'h0;
		o_reg_addr <= ~a;
		@(posedge i_sys_clk);
		d = i_reg_rdata;
	endtask : rd
	task automatic upload(input logic [5:0] idx, input logic [23:0] d);
		wr(dscu_pkg::ADDR_UNLOCK, {16'h0000, KEY});
		wr(dscu_pkg::ADDR_COEF_CTRL, {18'h00000, idx} | 24'h0000c0);
		wr(dscu_pkg::ADDR_COEF_DATA, d);
		@(posedge i_sys_clk);
		o_sync <= 1'h1;
		@(posedge i_sys_clk);
		o_sync <= 1'h0;
	endtask : upload
endmodule : dscu_host_model

// ===== diag_status_and_coeff_upload_tb.sv
`timescale 1ns/100ps
module diag_status_and_coeff_upload_tb;
	localparam logic [7:0] KEY = 8'h3c; // arbitrary value
	logic i_sys_clk = 1'h0, i_reset = 1'h1, i_reg_wr, i_reg_rd, i_sync, i_cs_framed = 1'h0, i_tick_enable = 1'h0;
	logic i_ev_ignore = 1'h0, i_ev_rd_err = 1'h0, i_ev_wr_err = 1'h0, i_ev_crc_err = 1'h0, i_ev_clk_cnt = 1'h0;
	logic [6:0] i_reg_addr;
	logic [23:0] i_reg_wdata, o_reg_rdata;
	logic [5:0] i_conv_fault = 6'h00;
	logic [4:2] i_dig_fault = 3'h0;
	logic o_conv_summary, o_missing_clock_fault, o_reload_rom, o_coef_unlocked;
	int n_errors = 0, n_tests = 0, n_reload = 0;
	always #2 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) if (o_reload_rom === 1'h1) n_reload++;
	dscu_regs #(.UNLOCK_KEY(KEY)) i_dut (.i_sys_clk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
		.o_reg_rdata, .i_ev_ignore, .i_ev_rd_err, .i_ev_wr_err, .i_ev_crc_err, .i_ev_clk_cnt, .i_cs_framed,
		.i_conv_fault, .i_dig_fault, .i_tick_enable, .i_sync, .o_conv_summary, .o_missing_clock_fault,
		.o_reload_rom, .o_coef_unlocked);
	dscu_host_model #(.KEY(KEY)) i_host (.i_sys_clk, .i_reg_rdata(o_reg_rdata), .o_reg_wr(i_reg_wr),
		.o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata), .o_sync(i_sync));
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rc(input logic [6:0] a, input logic [23:0] e);
		logic [23:0] v;
		i_host.rd(a, v);
		chk(v, e);
	endtask : rc
	task automatic pulse(input logic [4:0] ev, input logic framed);
		@(posedge i_sys_clk);
		{i_ev_ignore, i_ev_clk_cnt, i_ev_rd_err, i_ev_wr_err, i_ev_crc_err} <= ev;
		i_cs_framed <= framed;
		@(posedge i_sys_clk);
		{i_ev_ignore, i_ev_clk_cnt, i_ev_rd_err, i_ev_wr_err, i_ev_crc_err} <= 5'h00;
	endtask : pulse
	task automatic results;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	task automatic t_reset;
		for (int a = 'h2e; a <= 'h35; a++)
			rc(7'(a), 24'h000000);
		$display("reset values done");
	endtask : t_reset
	task automatic t_spi;
		pulse(5'h08, 1'h0);
		rc(dscu_pkg::ADDR_SPI_ERR, 24'h000000);
		pulse(5'h1f, 1'h1);
		rc(dscu_pkg::ADDR_SPI_ERR, 24'h00001f);
		i_host.wr(dscu_pkg::ADDR_SPI_ERR, 24'hffffff);
		rc(dscu_pkg::ADDR_SPI_ERR, 24'h000008);
		$display("interface errors done");
	endtask : t_spi
	task automatic t_fault;
		@(posedge i_sys_clk);
		i_conv_fault <= 6'h3f;
		i_dig_fault <= 3'h7;
		repeat (5) @(posedge i_sys_clk);
		rc(dscu_pkg::ADDR_DIG_FAULT, 24'h00001c);
		i_host.wr(dscu_pkg::ADDR_CONV_FAULT, 24'h000000);
		rc(dscu_pkg::ADDR_CONV_FAULT, 24'h00003f);
		chk(24'({o_conv_summary, o_missing_clock_fault}), 24'h000003);
		i_conv_fault <= 6'h01;
		repeat (5) @(posedge i_sys_clk);
		chk(24'({o_conv_summary, o_missing_clock_fault}), 24'h000001);
		i_conv_fault <= 6'h00;
		i_dig_fault <= 3'h0;
		$display("fault status done");
	endtask : t_fault
	task automatic t_tick(input int n, input logic en, input logic [7:0] inc);
		logic [23:0] v0, v1;
		@(posedge i_sys_clk);
		i_tick_enable <= en;
		i_host.rd(dscu_pkg::ADDR_TICK_CNT, v0);
		repeat (n) @(posedge i_sys_clk);
		i_host.rd(dscu_pkg::ADDR_TICK_CNT, v1);
		chk(v1, {16'h0000, v0[7:0] + inc});
		$display("tick counter done");
	endtask : t_tick
	task automatic t_coef;
		i_host.wr(dscu_pkg::ADDR_UNLOCK, {16'h0000, ~KEY});
		rc(dscu_pkg::ADDR_UNLOCK, 24'h000000);
		i_host.upload(6'h05, 24'h800123);
		rc(dscu_pkg::ADDR_UNLOCK, 24'h000001);
		rc(dscu_pkg::ADDR_COEF_DATA, 24'h800123);
		i_host.wr(dscu_pkg::ADDR_COEF_CTRL, 24'h000085);
		i_host.wr(dscu_pkg::ADDR_COEF_DATA, 24'h000456);
		rc(dscu_pkg::ADDR_COEF_DATA, 24'h800123);
		i_host.wr(dscu_pkg::ADDR_COEF_CTRL, 24'h000045);
		i_host.wr(dscu_pkg::ADDR_COEF_DATA, 24'h000789);
		i_host.wr(dscu_pkg::ADDR_COEF_CTRL, 24'h000085);
		rc(dscu_pkg::ADDR_COEF_DATA, 24'h800123);
		chk(24'(n_reload), 24'h000000);
		i_host.upload(6'h37, 24'h7fffff);
		rc(dscu_pkg::ADDR_COEF_DATA, 24'h7fffff);
		rc(dscu_pkg::ADDR_COEF_CTRL, 24'h0000f7);
		chk(24'(n_reload), 24'h000001);
		$display("coefficient upload done");
	endtask : t_coef
	initial
	begin
		repeat (40000) @(posedge i_sys_clk);
		n_errors++;
		results();
	end
	initial
	begin
		repeat (16) @(posedge i_sys_clk);
		i_reset <= 1'h0;
		t_reset();
		t_spi();
		t_fault();
		t_tick(61, 1'h1, 8'h01);
		t_tick(16445, 1'h1, 8'h01);
		t_tick(61, 1'h0, 8'h00);
		t_coef();
		results();
	end
endmodule : diag_status_and_coeff_upload_tb
